// ### rtl/eivp_consts.vh
// constants for external request pin and vector priority block
`ifndef EIVP_CONSTS_VH
`define EIVP_CONSTS_VH
// register word offsets
`define EIVP_OFS_CTRL_STAT 4'h0
`define EIVP_OFS_VEC_STAT 4'h1
`define EIVP_OFS_VEC_ADDR 4'h2
`define EIVP_OFS_PIN_STAT 4'h3
`define EIVP_OFS_PEND_LO 4'h4
`define EIVP_OFS_PEND_HI 4'h5
// control and status field positions
`define EIVP_BIT_MODE 0
`define EIVP_BIT_IE 1
`define EIVP_BIT_ACK 2
`define EIVP_BIT_FLAG 3
`define EIVP_BIT_PE 4
`define EIVP_BIT_POL 5
`define EIVP_BIT_PDD 6
// reset values
`define EIVP_CTRL_RST 7'h00
// vector numbers and addresses
`define EIVP_VEC_RESET 6'h00
`define EIVP_VEC_SWI 6'h01
`define EIVP_VEC_PIN 6'h02
`define EIVP_VEC_TOP 16'hFFFE
// numbers 32..47 are not vector space, 56..63 are reserved
`define EIVP_VEC_USED 64'h00FF_0000_FFFF_FFFF
`endif

// ### rtl/eivp_prio.v
// fixed priority selector, lowest vector number wins
`timescale 1ns/100ps
module eivp_prio #(
   parameter NVEC = 64,
   parameter NW = 6
) (
   // requests
   input wire [NVEC-1:0] req,
   input wire [NVEC-1:0] used,
   // result
   output reg valid,
   output reg [NW-1:0] num
);
   integer i;
   always @* begin
      valid = 1'b0;
      num = {NW{1'b0}};
      // scan downward so the lowest number is left standing
      for (i = NVEC - 1; i >= 0; i = i - 1) begin
         if (req[i] && used[i]) begin
            valid = 1'b1;
            num = i[NW-1:0];
         end
      end
   end
endmodule // eivp_prio

// ### rtl/eivp_top.v
// external request pin logic, vector priority and register slave
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "eivp_consts.vh"
module eivp_top #(
   parameter NVEC = 64,
   parameter NW = 6
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // avalon slave
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   // request pin
   input wire irq_pin,
   output reg pull_up_en,
   output reg pull_down_en,
   // stop mode and wake
   input wire stop_mode,
   output reg wake,
   // other sources, flag and local enable each except reset_src and swi_req
   input wire [NVEC-1:0] src_flag,
   input wire [NVEC-1:0] src_en,
   input wire [7:0] reset_src,
   input wire swi_req,
   // cpu side
   input wire cpu_i_mask,
   input wire cpu_vec_take,
   output reg cpu_int_req,
   output reg reset_req,
   output reg branch_if_pin_high,
   output reg branch_if_pin_low,
   output reg [15:0] vec_fetch_addr_hi,
   output reg [15:0] vec_fetch_addr_lo,
   output reg [NW-1:0] vec_num
);

   // asserted test for a pin level under a polarity
   function asserted_lvl;
      input lvl;
      input pol;
      begin
         asserted_lvl = pol ? lvl : ~lvl;
      end
   endfunction

   // control and status bits
   reg pull_disable;
   reg polarity_select;
   reg pin_function_enable;
   reg request_flag;
   reg pin_interrupt_enable;
   reg detect_mode_select;

   // pin synchroniser
   reg pin_s1;
   reg pin_s2;
   reg pin_s3;
   reg pin_lvl;
   reg pin_was_asserted;

   // bus decode
   wire wr_go;
   wire rd_go;
   wire sel_ctrl;
   wire [6:0] ctrl_wdata;
   wire ack_write;

   // detection
   wire pin_asserted;
   wire pin_edge;
   wire pin_event;
   wire next_request_flag;

   // vector selection
   wire [NVEC-1:0] req_vec;
   wire win_valid;
   wire [NW-1:0] win_num;
   wire [15:0] win_addr;
   reg [NW-1:0] win_num_q;
   reg win_valid_q;
   reg [NVEC-1:0] pend_q;

   // asynchronous wake path
   wire wake_clk;
   wire wake_clr_b;
   reg wake_s1;
   reg wake_s2;
   reg wake_s3;
   reg wake_seen;

   // assembled status words
   wire [31:0] ctrl_word;
   wire [31:0] vec_word;
   wire [31:0] pin_word;

   // reset image of the control and status bits
   localparam [6:0] CTRL_RST = `EIVP_CTRL_RST;

   // ---------------- bus slave ----------------
   assign wr_go = write && !waitrequest;
   assign rd_go = read && waitrequest;
   assign sel_ctrl = (address == `EIVP_OFS_CTRL_STAT);
   assign ctrl_wdata = writedata[6:0];
   assign ack_write = wr_go && sel_ctrl && ctrl_wdata[`EIVP_BIT_ACK];

   // one wait state on every access
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         waitrequest <= 1'b1;
      end else if ((read || write) && waitrequest) begin
         waitrequest <= 1'b0;
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // status words, acknowledge bit always reads 0
   assign ctrl_word = {25'h000_0000,
      pull_disable, polarity_select, pin_function_enable,
      request_flag, 1'b0,
      pin_interrupt_enable, detect_mode_select};
   assign vec_word = {21'h00_0000,
      reset_req, cpu_int_req, win_valid_q,
      {(8-NW){1'b0}}, win_num_q};
   assign pin_word = {28'h000_0000,
      wake_seen, pin_was_asserted,
      branch_if_pin_low, branch_if_pin_high};

   // read data latched as waitrequest drops
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         readdata <= 32'h0000_0000;
      end else if (rd_go) begin
         case (address)
            `EIVP_OFS_CTRL_STAT: begin
               readdata <= ctrl_word;
            end
            `EIVP_OFS_VEC_STAT: begin
               readdata <= vec_word;
            end
            `EIVP_OFS_VEC_ADDR: begin
               readdata <= {vec_fetch_addr_lo, vec_fetch_addr_hi};
            end
            `EIVP_OFS_PIN_STAT: begin
               readdata <= pin_word;
            end
            `EIVP_OFS_PEND_LO: begin
               readdata <= pend_q[31:0];
            end
            `EIVP_OFS_PEND_HI: begin
               readdata <= pend_q[63:32];
            end
            default: begin
               readdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // control register writes
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pull_disable <= CTRL_RST[`EIVP_BIT_PDD];
         polarity_select <= CTRL_RST[`EIVP_BIT_POL];
         pin_function_enable <= CTRL_RST[`EIVP_BIT_PE];
         pin_interrupt_enable <= CTRL_RST[`EIVP_BIT_IE];
         detect_mode_select <= CTRL_RST[`EIVP_BIT_MODE];
      end else if (wr_go && sel_ctrl) begin
         pull_disable <= ctrl_wdata[`EIVP_BIT_PDD];
         polarity_select <= ctrl_wdata[`EIVP_BIT_POL];
         pin_function_enable <= ctrl_wdata[`EIVP_BIT_PE];
         pin_interrupt_enable <= ctrl_wdata[`EIVP_BIT_IE];
         detect_mode_select <= ctrl_wdata[`EIVP_BIT_MODE];
      end
   end

   // ---------------- pin detection ----------------
   // three stages; level moves only when stages two and three agree
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_s3 <= 1'b0;
         pin_lvl <= 1'b0;
      end else begin
         pin_s1 <= irq_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         if (pin_s2 == pin_s3) begin
            pin_lvl <= pin_s3;
         end
      end
   end

   assign pin_asserted = pin_function_enable && asserted_lvl(pin_lvl, polarity_select);

   // previous asserted state, cleared while the pin is off
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_was_asserted <= 1'b0;
      end else begin
         pin_was_asserted <= pin_asserted;
      end
   end

   assign pin_edge = pin_asserted && !pin_was_asserted;
   assign pin_event = pin_edge || (detect_mode_select && pin_asserted);

   // set wins over acknowledge
   assign next_request_flag = pin_event ? 1'b1 : (ack_write ? 1'b0 : request_flag);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         request_flag <= CTRL_RST[`EIVP_BIT_FLAG];
      end else begin
         request_flag <= next_request_flag;
      end
   end

   // pin level for branch instructions
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         branch_if_pin_high <= 1'b0;
         branch_if_pin_low <= 1'b0;
      end else begin
         branch_if_pin_high <= pin_function_enable && pin_lvl;
         branch_if_pin_low <= pin_function_enable && !pin_lvl;
      end
   end

   // pull device choice
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pull_up_en <= 1'b0;
         pull_down_en <= 1'b0;
      end else begin
         pull_up_en <= pin_function_enable && !pull_disable && !polarity_select;
         pull_down_en <= pin_function_enable && !pull_disable && polarity_select;
      end
   end

   // ---------------- stop mode wake ----------------
   // the pin itself clocks the wake flop while clocks are stopped
   assign wake_clk = pin_function_enable && stop_mode &&
      asserted_lvl(irq_pin, polarity_select);
   assign wake_clr_b = rst_b && stop_mode;

   always @(posedge wake_clk or negedge wake_clr_b) begin
      if (!wake_clr_b) begin
         wake <= 1'b0;
      end else begin
         wake <= 1'b1;
      end
   end

   // wake seen by bus logic, three stages against metastability
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_s1 <= 1'b0;
         wake_s2 <= 1'b0;
         wake_s3 <= 1'b0;
         wake_seen <= 1'b0;
      end else begin
         wake_s1 <= wake;
         wake_s2 <= wake_s1;
         wake_s3 <= wake_s2;
         if (wake_s2 == wake_s3) begin
            wake_seen <= wake_s3;
         end
      end
   end

   // ---------------- vector priority ----------------
   genvar g;
   generate
      for (g = 0; g < NVEC; g = g + 1) begin : g_req
         if (g == `EIVP_VEC_RESET) begin : g_rst
            assign req_vec[g] = |reset_src;
         end else if (g == `EIVP_VEC_SWI) begin : g_swi
            assign req_vec[g] = swi_req;
         end else if (g == `EIVP_VEC_PIN) begin : g_pin
            assign req_vec[g] = request_flag && pin_interrupt_enable;
         end else begin : g_src
            assign req_vec[g] = src_flag[g] && src_en[g];
         end
      end
   endgenerate

   eivp_prio #(
      .NVEC(NVEC),
      .NW(NW)
   ) u_prio (
      .req(req_vec),
      .used(`EIVP_VEC_USED),
      .valid(win_valid),
      .num(win_num)
   );

   // top address minus twice the number
   assign win_addr = `EIVP_VEC_TOP - {{(15-NW){1'b0}}, win_num, 1'b0};

   // registered winner and pending image
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         win_num_q <= {NW{1'b0}};
         win_valid_q <= 1'b0;
         pend_q <= {NVEC{1'b0}};
      end else begin
         win_num_q <= win_num;
         win_valid_q <= win_valid;
         pend_q <= req_vec & `EIVP_VEC_USED;
      end
   end

   // cpu request lines
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_int_req <= 1'b0;
         reset_req <= 1'b0;
      end else begin
         // reset is not maskable; the rest wait for mask 0
         reset_req <= |reset_src;
         cpu_int_req <= win_valid && !cpu_i_mask &&
            (win_num != `EIVP_VEC_RESET);
      end
   end

   // vector fetch addresses captured when the cpu has stacked
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vec_fetch_addr_hi <= `EIVP_VEC_TOP;
         vec_fetch_addr_lo <= `EIVP_VEC_TOP + 16'h0001;
         vec_num <= `EIVP_VEC_RESET;
      end else if (cpu_vec_take && win_valid) begin
         vec_fetch_addr_hi <= win_addr;
         vec_fetch_addr_lo <= win_addr + 16'h0001;
         vec_num <= win_num;
      end
   end

endmodule // eivp_top

// ### testbench/eivp_pin_dev.sv
// outside device driving the request pin
`timescale 1ns/100ps
module eivp_pin_dev (
   // bench control
   input wire logic clk,
   input wire logic drv_en,
   input wire logic drv_lvl,
   // pull devices of the block
   input wire logic pull_up_en,
   input wire logic pull_down_en,
   // pin
   output logic irq_pin
);
   logic last = 1'b0;
   // released pin with no pull flips each cycle
   always @(posedge clk) begin
      last <= irq_pin;
   end
   always @* begin
      if (drv_en) irq_pin = drv_lvl;
      else if (pull_up_en) irq_pin = 1'b1;
      else if (pull_down_en) irq_pin = 1'b0;
      else irq_pin = ~last;
   end
endmodule // eivp_pin_dev

// ### testbench/eivp_top_sva.sv
// assertions on the ports of the pin and vector block
`timescale 1ns/100ps
module eivp_sva #(parameter NVEC = 64, parameter NW = 6) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // bus
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic [31:0] readdata,
   // pin and stop
   input wire logic pull_up_en,
   input wire logic pull_down_en,
   input wire logic stop_mode,
   input wire logic wake,
   // cpu side
   input wire logic [7:0] reset_src,
   input wire logic cpu_i_mask,
   input wire logic cpu_vec_take,
   input wire logic cpu_int_req,
   input wire logic reset_req,
   input wire logic branch_if_pin_high,
   input wire logic branch_if_pin_low,
   input wire logic [15:0] vec_fetch_addr_hi,
   input wire logic [15:0] vec_fetch_addr_lo,
   input wire logic [NW-1:0] vec_num
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_lo; vec_fetch_addr_lo == vec_fetch_addr_hi + 16'h0001; endproperty
   a_lo: assert property (p_lo) else $error("low byte address wrong");
   property p_addr; vec_fetch_addr_hi == 16'hFFFE - {vec_num, 1'b0}; endproperty
   a_addr: assert property (p_addr) else $error("vector address wrong");
   property p_rstq; reset_req == (|$past(reset_src)); endproperty
   a_rstq: assert property (p_rstq) else $error("reset request wrong");
   property p_mask; $past(cpu_i_mask) |-> !cpu_int_req; endproperty
   a_mask: assert property (p_mask) else $error("request while masked");
   property p_rvec; cpu_vec_take && (|reset_src) |=> vec_num == 6'h00; endproperty
   a_rvec: assert property (p_rvec) else $error("reset not chosen");
   property p_pull; !(pull_up_en && pull_down_en); endproperty
   a_pull: assert property (p_pull) else $error("both pulls on");
   property p_br; !(branch_if_pin_high && branch_if_pin_low); endproperty
   a_br: assert property (p_br) else $error("pin level both ways");
   property p_ack; read && !waitrequest && address == 4'h0 |-> !readdata[2]; endproperty
   a_ack: assert property (p_ack) else $error("acknowledge reads 1");
   property p_wake; !stop_mode && !$past(stop_mode) |-> !wake; endproperty
   a_wake: assert property (p_wake) else $error("wake outside stop");
   property p_wait; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");
   c_int: cover property (cpu_vec_take && cpu_int_req);
   c_wake: cover property (wake);
   c_rst: cover property (reset_req);
endmodule // eivp_sva
bind eivp_top eivp_sva #(.NVEC(NVEC), .NW(NW)) eivp_sva_inst (.*);

// ### testbench/eivp_top_test.sv
// self-checking bench for the pin and vector block
`timescale 1ns/100ps
`include "eivp_consts.vh"
module ext_irq_pin_and_vector_priority_test;
   localparam logic [63:0] USED = `EIVP_VEC_USED;
   localparam logic [63:0] B55 = 64'h0080_0000_0000_0000;
   logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, stop_mode = 1'b0;
   logic swi_req = 1'b0, cpu_i_mask = 1'b1, cpu_vec_take = 1'b0;
   logic drv_en = 1'b1, drv_lvl = 1'b1;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0, readdata, q, st = 32'h34;
   logic [63:0] src_flag = 64'h0, src_en = 64'h0;
   logic [7:0] reset_src = 8'h00;
   logic waitrequest, irq_pin, pull_up_en, pull_down_en, wake, cpu_int_req, reset_req;
   logic branch_if_pin_high, branch_if_pin_low;
   logic [15:0] vec_fetch_addr_hi, vec_fetch_addr_lo;
   logic [5:0] vec_num;
   integer n_fail = 0, check_count = 0, cyc = 0, i, e;
   integer exp_q[$];
   eivp_top eivp_top_inst (.*);
   eivp_pin_dev eivp_pin_dev_inst (.*);
   initial begin
      forever #2.5 clk = ~clk;
   end
   task end_sim;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         end_sim;
      end
   end
   task chk(input string nm, input logic [63:0] s, input logic [63:0] x);
      check_count = check_count + 1;
      if (s !== x) begin
         n_fail = n_fail + 1;
         $display("unexpected %s exp %h seen %h", nm, x, s);
      end
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      address <= a;
      write <= w;
      read <= ~w;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   function logic [31:0] xs;
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   // lowest requesting vector number from 3 up, 99 if none
   function integer win(input logic [63:0] f, input logic [63:0] en);
      win = 99;
      for (int n = 63; n > 2; n--) if (USED[n] && f[n] && en[n]) win = n;
   endfunction
   task take(input integer x);
      cpu_vec_take <= 1'b1;
      @(posedge clk);
      cpu_vec_take <= 1'b0;
      #1;
      chk("vec_num", vec_num, x);
      chk("vec_hi", vec_fetch_addr_hi, `EIVP_VEC_TOP - 2 * x);
      chk("vec_lo", vec_fetch_addr_lo, `EIVP_VEC_TOP + 1 - 2 * x);
      @(posedge clk);
   endtask
   task pin(input logic v);
      drv_lvl <= v;
      repeat (8) @(posedge clk);
      bus(1'b0, `EIVP_OFS_CTRL_STAT, 32'h0);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("wait", waitrequest, 1'b1);
      chk("lo", vec_fetch_addr_lo, 16'hFFFF);
      bus(1'b0, `EIVP_OFS_CTRL_STAT, 32'h0);
      chk("ctrl", q, `EIVP_CTRL_RST);
      bus(1'b0, 4'h7, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h12);
      chk("pull_up", pull_up_en, 1'b1);
      chk("pull_dn", pull_down_en, 1'b0);
      pin(1'b0);
      chk("flag", q[3], 1'b1);
      chk("pin_low", branch_if_pin_low, 1'b1);
      chk("int", cpu_int_req, 1'b0);
      cpu_i_mask <= 1'b0;
      repeat (3) @(posedge clk);
      chk("int", cpu_int_req, 1'b1);
      take(2);
      bus(1'b0, `EIVP_OFS_VEC_STAT, 32'h0);
      chk("vec_stat", q, 32'h0000_0302);
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h16);
      pin(1'b0);
      chk("flag", q[3], 1'b0);
      chk("ack", q[2], 1'b0);
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h10);
      pin(1'b1);
      pin(1'b0);
      chk("flag", q[3], 1'b1);
      chk("int", cpu_int_req, 1'b0);
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h15);
      pin(1'b0);
      chk("flag", q[3], 1'b1);
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h35);
      pin(1'b0);
      chk("pull_dn", pull_down_en, 1'b1);
      chk("pull_up", pull_up_en, 1'b0);
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h34);
      pin(1'b1);
      chk("flag", q[3], 1'b1);
      chk("pin_high", branch_if_pin_high, 1'b1);
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h74);
      chk("pulls", {pull_up_en, pull_down_en}, 2'b00);
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h04);
      drv_en <= 1'b0;
      pin(1'b0);
      chk("flag", q[3], 1'b0);
      chk("pin_lvl", {branch_if_pin_high, branch_if_pin_low}, 2'b00);
      drv_en <= 1'b1;
      bus(1'b1, `EIVP_OFS_CTRL_STAT, 32'h30);
      pin(1'b0);
      stop_mode <= 1'b1;
      @(posedge clk);
      drv_lvl <= 1'b1;
      repeat (2) @(posedge clk);
      chk("wake", wake, 1'b1);
      repeat (3) @(posedge clk);
      bus(1'b0, `EIVP_OFS_PIN_STAT, 32'h0);
      chk("pin_stat", q[3:0], 4'hD);
      stop_mode <= 1'b0;
      repeat (2) @(posedge clk);
      chk("wake", wake, 1'b0);
      for (i = 0; i < 8; i++) begin
         reset_src <= 8'h01 << i;
         repeat (3) @(posedge clk);
         chk("reset_req", reset_req, 1'b1);
         take(0);
      end
      reset_src <= 8'h00;
      swi_req <= 1'b1;
      repeat (3) @(posedge clk);
      take(1);
      swi_req <= 1'b0;
      for (i = 0; i < 40; i++) begin
         src_flag <= {xs(), i < 8 ? 32'h0 : xs()} | B55;
         src_en <= {xs(), xs()} | B55;
         cpu_i_mask <= st[0];
         repeat (3) @(posedge clk);
         exp_q.push_back(win(src_flag, src_en));
         e = exp_q.pop_front();
         chk("int", cpu_int_req, !cpu_i_mask);
         take(e);
      end
      end_sim;
   end
endmodule // ext_irq_pin_and_vector_priority_test
